// ===== core/gtm_timer.sv
// How it works
// - 16-bit uses both pins, 32-bit even only
// - Config 0 selects 32-bit timer, 1 calendar
// - 32-bit load write fills both halves
// - 32-bit count read returns both halves
// - Half A mode alone picks one-shot/periodic
// - Count down, reload after zero next cycle
// - One-shot stops and clears enable; periodic continues
// - Time-out sets sticky raw, masked, interrupt
// - Enabled trigger pulses one cycle at zero
// - Load write while running reloads next cycle
// - Freeze bit holds the count except in edge-count mode
// - Calendar counts up from one, later match
// - Even pin 32.768 KHz divided to 1 Hz
// - Calendar match rolls over to zero
// - Calendar match sets raw, masked flags; clearable
// - Calendar override ignores freeze bits
// - Config 4 splits into two 16-bit halves
// - 16-bit down-count with prescaler, reload both
// - Prescale N gives N+1 clocks per count
// - Edge-count mode counts selected edge types
// - Each selected edge decrements until match
// - Edge match sets raw and masked flags
// - Edge match reloads, clears enable, ignores edges
// - Reset: counts and loads all ones
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gtm_timer #(
    parameter int unsigned RTC_DIV_P = gtm_pkg::RTC_DIV
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        ccp_even_i,
    input  wire logic        ccp_odd_i,
    output logic             trig_a_o,
    output logic             trig_b_o,
    output logic             irq_o
);
    import gtm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [2:0]  cfg_r,   cfg_nxt;
    logic [2:0]  mr_r     [2];
    logic [2:0]  mr_nxt   [2];
    logic [31:0] ctl_r,   ctl_nxt;
    logic [31:0] imr_r,   imr_nxt;
    logic [31:0] ris_r,   ris_nxt;
    logic [15:0] ilr_r    [2];
    logic [15:0] ilr_nxt  [2];
    logic [15:0] mat_r    [2];
    logic [15:0] mat_nxt  [2];
    logic [7:0]  pr_r     [2];
    logic [7:0]  pr_nxt   [2];
    logic [15:0] cnt_r    [2];
    logic [15:0] cnt_nxt  [2];
    logic [7:0]  pcnt_r   [2];
    logic [7:0]  pcnt_nxt [2];
    logic [1:0]  trig_r,  trig_nxt;
    logic [15:0] div_r,   div_nxt;
    logic [31:0] dat_r;
    logic        ack_r;
    logic [31:0] st_set;
    logic [31:0] st_clr;
    logic [31:0] c32;

    // Pin synchronisers: index 0 even pin, 1 odd pin
    logic [1:0]  pin_s1_r;
    logic [1:0]  pin_s2_r;
    logic [1:0]  pin_s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire         is_rtc   = (cfg_r == CFG_RTC);
    wire         is_split = (cfg_r == CFG_SPLIT);
    wire         is_t32   = !is_rtc && !is_split;
    wire  [31:0] cnt32    = {cnt_r[1], cnt_r[0]};
    wire  [31:0] ilr32    = {ilr_r[1], ilr_r[0]};
    wire  [31:0] mat32    = {mat_r[1], mat_r[0]};
    wire  [31:0] bmask    = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire         req      = cyc_i && stb_i;
    wire         wr       = req && we_i && ack_r;
    wire  [31:0] mis      = ris_r & imr_r;
    wire  [1:0]  rise     = pin_s2_r & ~pin_s3_r;
    wire  [1:0]  fall     = ~pin_s2_r & pin_s3_r;
    wire         rtc_tick = rise[0] && (div_r == 16'(RTC_DIV_P - 1));

    // Half B takes the odd pin only when split
    wire  [1:0]  src_rise = {is_split ? rise[1] : rise[0], rise[0]};
    wire  [1:0]  src_fall = {is_split ? fall[1] : fall[0], fall[0]};

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [31:0] m);
        return (old & ~m) | (dat & m);
    endfunction

    function automatic logic edge_hit(input logic [1:0] ev,
                                      input logic       r,
                                      input logic       f);
        return ((ev == EV_RISE) && r) || ((ev == EV_FALL) && f) ||
               ((ev == EV_BOTH) && (r || f));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Per-half control bits; index 0 is half A, 1 is half B
    wire  [1:0]  en_h;
    wire  [1:0]  stall_h;
    wire  [1:0]  ote_h;
    wire  [1:0]  hit_h;
    wire  [1:0]  zero_h;

    for (genvar g = 0; g < 2; g++) begin : g_half
        assign en_h[g]    = ctl_r[g*CTL_STRIDE + CTL_EN];
        assign stall_h[g] = ctl_r[g*CTL_STRIDE + CTL_STALL];
        assign ote_h[g]   = ctl_r[g*CTL_STRIDE + CTL_OTE];
        assign hit_h[g]   = edge_hit(ctl_r[g*CTL_STRIDE + CTL_EV +: 2],
                                     src_rise[g], src_fall[g]);
        assign zero_h[g]  = (cnt_r[g] == 16'h0);
    end

    wire  [31:0] w_cfg    = wmerge({29'h0, cfg_r}, dat_i, bmask);
    wire  [31:0] w_ctl    = wmerge(ctl_r, dat_i, bmask) & CTL_MASK;
    wire  [31:0] w_imr    = wmerge(imr_r, dat_i, bmask) & ST_MASK;
    wire  [31:0] w_ailr   = wmerge(is_split ? {16'h0, ilr_r[0]} : ilr32, dat_i, bmask);
    wire  [31:0] w_bilr   = wmerge({16'h0, ilr_r[1]}, dat_i, bmask);
    wire  [31:0] w_amat   = wmerge(is_split ? {16'h0, mat_r[0]} : mat32, dat_i, bmask);
    wire  [31:0] w_bmat   = wmerge({16'h0, mat_r[1]}, dat_i, bmask);
    wire  [31:0] w_amr    = wmerge({29'h0, mr_r[0]}, dat_i, bmask);
    wire  [31:0] w_bmr    = wmerge({29'h0, mr_r[1]}, dat_i, bmask);
    wire  [31:0] w_apr    = wmerge({24'h0, pr_r[0]}, dat_i, bmask);
    wire  [31:0] w_bpr    = wmerge({24'h0, pr_r[1]}, dat_i, bmask);

    // Read mux; unmapped addresses read as zero
    wire  [31:0] rd_data  =
        (adr_i == OFS_CFG)    ? {29'h0, cfg_r} :
        (adr_i == OFS_AMR)    ? {29'h0, mr_r[0]} :
        (adr_i == OFS_BMR)    ? {29'h0, mr_r[1]} :
        (adr_i == OFS_CTL)    ? ctl_r :
        (adr_i == OFS_IMR)    ? imr_r :
        (adr_i == OFS_RIS)    ? ris_r :
        (adr_i == OFS_MIS)    ? mis :
        (adr_i == OFS_AILR)   ? (is_split ? {16'h0, ilr_r[0]} : ilr32) :
        (adr_i == OFS_BILR)   ? {16'h0, ilr_r[1]} :
        (adr_i == OFS_AMATCH) ? (is_split ? {16'h0, mat_r[0]} : mat32) :
        (adr_i == OFS_BMATCH) ? {16'h0, mat_r[1]} :
        (adr_i == OFS_APR)    ? {24'h0, pr_r[0]} :
        (adr_i == OFS_BPR)    ? {24'h0, pr_r[1]} :
        (adr_i == OFS_AR)     ? (is_split ? {16'h0, cnt_r[0]} : cnt32) :
        (adr_i == OFS_BR)     ? {16'h0, cnt_r[1]} :
                                32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Counting and register writes
    always_comb begin
        cfg_nxt  = cfg_r;
        mr_nxt   = mr_r;
        ctl_nxt  = ctl_r;
        imr_nxt  = imr_r;
        ilr_nxt  = ilr_r;
        mat_nxt  = mat_r;
        pr_nxt   = pr_r;
        cnt_nxt  = cnt_r;
        pcnt_nxt = pcnt_r;
        trig_nxt = 2'b00;
        div_nxt  = div_r;
        st_set   = 32'h0;
        st_clr   = 32'h0;
        c32      = cnt32;

        if (is_rtc) begin
            // Override keeps the calendar running through freeze requests
            if (ctl_r[CTL_EN] && (ctl_r[CTL_CALENDAR_FREEZE_OVERRIDE] ||
                !(ctl_r[CTL_STALL] || ctl_r[CTL_STRIDE + CTL_STALL]))) begin
                if (rise[0]) begin
                    div_nxt = rtc_tick ? 16'h0 : div_r + 16'h1;
                end
                if (rtc_tick) begin
                    if (cnt32 == mat32) begin
                        c32                = RTC_ROLL;
                        st_set[ST_RTC]     = 1'b1;
                    end else begin
                        c32 = cnt32 + 32'h1;
                    end
                end
            end
            // Divider restarts while stopped so a new run begins on a whole tick
            if (!ctl_r[CTL_EN]) begin
                div_nxt = 16'h0;
            end
            cnt_nxt[0] = c32[15:0];
            cnt_nxt[1] = c32[31:16];
        end else if (is_t32) begin
            div_nxt = 16'h0;
            if (ctl_r[CTL_EN] && !ctl_r[CTL_STALL]) begin
                // Count rests at zero for one cycle, reload comes on the next
                if (cnt32 == 32'h0) begin
                    c32            = ilr32;
                    st_set[ST_TO]  = 1'b1;
                    if (mr_r[0][1:0] == MODE_ONESHOT) begin
                        ctl_nxt[CTL_EN] = 1'b0;
                    end
                end else begin
                    c32 = cnt32 - 32'h1;
                    trig_nxt[0] = ctl_r[CTL_OTE] && (cnt32 == 32'h1);
                end
            end
            cnt_nxt[0] = c32[15:0];
            cnt_nxt[1] = c32[31:16];
        end else begin
            div_nxt = 16'h0;
            for (int i = 0; i < 2; i++) begin
                if (mr_r[i][1:0] == MODE_CAPTURE) begin
                    // Edge-time capture is not built; only edge count runs
                    if (!mr_r[i][MR_CMR] && en_h[i] && hit_h[i]) begin
                        // Match is judged on the count this edge would leave
                        if ((cnt_r[i] - 16'h1) == mat_r[i]) begin
                            cnt_nxt[i]                        = ilr_r[i];
                            ctl_nxt[i*CTL_STRIDE + CTL_EN]    = 1'b0;
                            st_set[i*ST_STRIDE + ST_CM]       = 1'b1;
                        end else begin
                            cnt_nxt[i] = cnt_r[i] - 16'h1;
                        end
                    end
                end else if (en_h[i] && !stall_h[i]) begin
                    // Prescaler runs N down to 0 per step: N+1 clocks a count
                    if (zero_h[i]) begin
                        cnt_nxt[i]                  = ilr_r[i];
                        pcnt_nxt[i]                 = pr_r[i];
                        st_set[i*ST_STRIDE + ST_TO] = 1'b1;
                        if (mr_r[i][1:0] == MODE_ONESHOT) begin
                            ctl_nxt[i*CTL_STRIDE + CTL_EN] = 1'b0;
                        end
                    end else if (pcnt_r[i] != 8'h0) begin
                        pcnt_nxt[i] = pcnt_r[i] - 8'h1;
                    end else begin
                        pcnt_nxt[i] = pr_r[i];
                        cnt_nxt[i]  = cnt_r[i] - 16'h1;
                        trig_nxt[i] = ote_h[i] && (cnt_r[i] == 16'h1);
                    end
                end
            end
        end

        // Bus writes come last so a software write wins over counting, except an ICR clear of a flag set that cycle
        if (wr) begin
            if (adr_i == OFS_CFG) begin
                cfg_nxt = w_cfg[2:0];
                // Only entering calendar mode presets the count, not a rewrite
                if ((w_cfg[2:0] == CFG_RTC) && !is_rtc) begin
                    cnt_nxt[0] = RTC_START[15:0];
                    cnt_nxt[1] = RTC_START[31:16];
                end
            end else if (adr_i == OFS_AMR) begin
                mr_nxt[0] = w_amr[2:0];
            end else if (adr_i == OFS_BMR) begin
                mr_nxt[1] = w_bmr[2:0];
            end else if (adr_i == OFS_CTL) begin
                // Software enable writes win over a same-cycle hardware clear
                ctl_nxt = w_ctl;
            end else if (adr_i == OFS_IMR) begin
                imr_nxt = w_imr;
            end else if (adr_i == OFS_ICR) begin
                st_clr = dat_i & bmask & ST_MASK;
            end else if (adr_i == OFS_AILR) begin
                // A load write restarts the count now rather than at zero
                ilr_nxt[0] = w_ailr[15:0];
                cnt_nxt[0] = w_ailr[15:0];
                if (!is_split) begin
                    ilr_nxt[1] = w_ailr[31:16];
                    cnt_nxt[1] = w_ailr[31:16];
                end
            end else if (adr_i == OFS_BILR) begin
                ilr_nxt[1] = w_bilr[15:0];
                cnt_nxt[1] = w_bilr[15:0];
            end else if (adr_i == OFS_AMATCH) begin
                mat_nxt[0] = w_amat[15:0];
                if (!is_split) begin
                    mat_nxt[1] = w_amat[31:16];
                end
            end else if (adr_i == OFS_BMATCH) begin
                mat_nxt[1] = w_bmat[15:0];
            end else if (adr_i == OFS_APR) begin
                // Prescale writes restart the prescale count as well
                pr_nxt[0]   = w_apr[7:0];
                pcnt_nxt[0] = w_apr[7:0];
            end else if (adr_i == OFS_BPR) begin
                pr_nxt[1]   = w_bpr[7:0];
                pcnt_nxt[1] = w_bpr[7:0];
            end
        end

        // A flag raised in the cycle it is cleared stays set
        ris_nxt = (ris_r & ~st_clr) | st_set;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r  <= CFG_T32;
            ctl_r  <= 32'h0;
            imr_r  <= 32'h0;
            ris_r  <= 32'h0;
            trig_r <= 2'b00;
            div_r  <= 16'h0;
            for (int i = 0; i < 2; i++) begin
                mr_r[i]   <= 3'h0;
                ilr_r[i]  <= CNT_RST;
                cnt_r[i]  <= CNT_RST;
                mat_r[i]  <= CNT_RST;
                pr_r[i]   <= PCNT_RST;
                pcnt_r[i] <= PCNT_RST;
            end
        end else begin
            cfg_r  <= cfg_nxt;
            ctl_r  <= ctl_nxt;
            imr_r  <= imr_nxt;
            ris_r  <= ris_nxt;
            trig_r <= trig_nxt;
            div_r  <= div_nxt;
            mr_r   <= mr_nxt;
            ilr_r  <= ilr_nxt;
            cnt_r  <= cnt_nxt;
            mat_r  <= mat_nxt;
            pr_r   <= pr_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    // Two-flop synchroniser, third stage only feeds edge detection
    // Stages reset low, the pins' idle level, so no false edge follows reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 2'b00;
            pin_s2_r <= 2'b00;
            pin_s3_r <= 2'b00;
        end else begin
            pin_s1_r <= {ccp_odd_i, ccp_even_i};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Bus slave: one wait state, data captured with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0;
        end else begin
            ack_r <= req && !ack_r;
            dat_r <= (req && !ack_r && !we_i) ? rd_data : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    // Interrupt is a plain OR of masked status, holding no state of its own
    assign ack_o    = ack_r;
    assign dat_o    = dat_r;
    assign trig_a_o = trig_r[0];
    assign trig_b_o = trig_r[1];
    assign irq_o    = |mis;

endmodule

`default_nettype wire

// ===== core/gtm_pkg.sv
package gtm_pkg;

    // Register byte offsets
    localparam logic [7:0]  OFS_CFG      = 8'h00;
    localparam logic [7:0]  OFS_AMR      = 8'h04;
    localparam logic [7:0]  OFS_BMR      = 8'h08;
    localparam logic [7:0]  OFS_CTL      = 8'h0c;
    localparam logic [7:0]  OFS_IMR      = 8'h18;
    localparam logic [7:0]  OFS_RIS      = 8'h1c;
    localparam logic [7:0]  OFS_MIS      = 8'h20;
    localparam logic [7:0]  OFS_ICR      = 8'h24;
    localparam logic [7:0]  OFS_AILR     = 8'h28;
    localparam logic [7:0]  OFS_BILR     = 8'h2c;
    localparam logic [7:0]  OFS_AMATCH   = 8'h30;
    localparam logic [7:0]  OFS_BMATCH   = 8'h34;
    localparam logic [7:0]  OFS_APR      = 8'h38;
    localparam logic [7:0]  OFS_BPR      = 8'h3c;
    localparam logic [7:0]  OFS_AR       = 8'h48;
    localparam logic [7:0]  OFS_BR       = 8'h4c;

    // Configuration values
    localparam logic [2:0]  CFG_T32      = 3'h0;
    localparam logic [2:0]  CFG_RTC      = 3'h1;
    localparam logic [2:0]  CFG_SPLIT    = 3'h4;

    // Mode register fields
    localparam logic [1:0]  MODE_ONESHOT = 2'h1;
    localparam logic [1:0]  MODE_PERIOD  = 2'h2;
    localparam logic [1:0]  MODE_CAPTURE = 2'h3;
    localparam int          MR_CMR       = 2;

    // Control register: half A at bit 0, half B at bit 8
    localparam int          CTL_STRIDE   = 8;
    localparam int          CTL_EN       = 0;
    localparam int          CTL_STALL    = 1;
    localparam int          CTL_EV       = 2;
    localparam int          CTL_CALENDAR_FREEZE_OVERRIDE    = 4;
    localparam int          CTL_OTE      = 5;
    localparam logic [31:0] CTL_MASK     = 32'h0000_2f3f;

    // Edge select encodings
    localparam logic [1:0]  EV_RISE      = 2'h0;
    localparam logic [1:0]  EV_FALL      = 2'h1;
    localparam logic [1:0]  EV_BOTH      = 2'h3;

    // Status bits: half A at bit 0, half B at bit 8
    localparam int          ST_STRIDE    = 8;
    localparam int          ST_TO        = 0;
    localparam int          ST_CM        = 2;
    localparam int          ST_RTC       = 3;
    localparam logic [31:0] ST_MASK      = 32'h0000_050d;

    // Reset and load values
    localparam logic [15:0] CNT_RST      = 16'hffff;
    localparam logic [7:0]  PCNT_RST     = 8'h00;
    localparam logic [31:0] RTC_START    = 32'h0000_0001;
    localparam logic [31:0] RTC_ROLL     = 32'h0000_0000;

    // Calendar clock division
    localparam int unsigned RTC_CLK_HZ   = 32768;
    localparam int unsigned RTC_TICK_HZ  = 1;
    localparam int unsigned RTC_DIV      = RTC_CLK_HZ / RTC_TICK_HZ;

endpackage

// ===== bench/gtm_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module gtm_timer_assertions #(
    parameter int unsigned RTC_DIV_P = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        ccp_even_i,
    input wire logic        ccp_odd_i,
    input wire logic        trig_a_o,
    input wire logic        trig_b_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////
    a_ack_one_late: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_read_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_trig_a_pulse: assert property (trig_a_o |=> !trig_a_o)
        else $error("half A trigger longer than one cycle");
    a_trig_b_pulse: assert property (trig_b_o |=> !trig_b_o)
        else $error("half B trigger longer than one cycle");
    // Status only clears by a register write, so irq may fall only after one
    a_irq_sticky: assert property ($fell(irq_o) |-> $past(ack_o && we_i))
        else $error("irq dropped without a register write");
    a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> !ack_o && !irq_o && !trig_a_o && !trig_b_o && dat_o == 32'h0)
        else $error("outputs not quiet after reset");
    c_trig_a: cover property (trig_a_o);
    c_trig_b: cover property (trig_b_o);
    c_irq: cover property ($rose(irq_o));
endmodule

bind gtm_timer gtm_timer_assertions #(.RTC_DIV_P(RTC_DIV_P)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ccp_even_i(ccp_even_i), .ccp_odd_i(ccp_odd_i), .trig_a_o(trig_a_o),
    .trig_b_o(trig_b_o), .irq_o(irq_o));

`default_nettype wire

// ===== bench/gtm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gtm_pin_model #(
    parameter int HALF_P = 3
) (
    input  wire logic clk_i,
    input  wire logic cal_run_i,
    input  wire logic tgl_odd_i,
    output logic      even_o,
    output logic      odd_o
);
    int cnt_r;
    initial begin
        even_o = 1'b0;
        odd_o = 1'b0;
        cnt_r = 0;
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (!cal_run_i) begin
            cnt_r <= 0;
            even_o <= 1'b0; // Slow clock stands still outside runs
        end else if (cnt_r == HALF_P - 1) begin
            cnt_r <= 0;
            even_o <= ~even_o;
        end else begin
            cnt_r <= cnt_r + 1;
        end
        if (tgl_odd_i) begin
            odd_o <= ~odd_o;
        end
    end
endmodule

`default_nettype wire

// ===== bench/gtm_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module gtm_timer_tb;
    import gtm_pkg::*;
    typedef struct packed {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [31:0] exp;
    } gtm_row_t;
    localparam gtm_row_t ROWS [11] = '{
        '{1'b0, OFS_CFG, 32'h0, 32'h0}, '{1'b0, OFS_CTL, 32'h0, 32'h0},
        '{1'b0, OFS_AR, 32'h0, 32'hffffffff}, '{1'b0, OFS_AILR, 32'h0, 32'hffffffff},
        '{1'b0, OFS_APR, 32'h0, 32'h0}, '{1'b1, OFS_AILR, 32'h12345678, 32'h0},
        '{1'b0, OFS_BILR, 32'h0, 32'h1234}, '{1'b0, OFS_AR, 32'h0, 32'h12345678},
        '{1'b1, OFS_RIS, 32'hffffffff, 32'h0}, '{1'b0, OFS_RIS, 32'h0, 32'h0},
        '{1'b0, 8'h10, 32'h0, 32'h0}};
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, even, odd;
    logic        trig_a, trig_b, irq, cal_run, tgl_odd;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, rd, q;
    logic [1:0]  evs [3] = '{EV_RISE, EV_FALL, EV_BOTH};
    int          mismatches = 0, checks = 0, cycles = 0, n;

    gtm_timer #(.RTC_DIV_P(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .ccp_even_i(even), .ccp_odd_i(odd),
        .trig_a_o(trig_a), .trig_b_o(trig_b), .irq_o(irq));
    gtm_pin_model #(.HALF_P(3)) u_pins (.clk_i(clk_i), .cal_run_i(cal_run),
        .tgl_odd_i(tgl_odd), .even_o(even), .odd_o(odd));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    // Request held until ack is seen at an edge; data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic wait_for(input logic [2:0] m);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (({irq, trig_b, trig_a} & m) !== m && n < 400);
        if (({irq, trig_b, trig_a} & m) !== m) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic run_rows();
        foreach (ROWS[i]) begin
            if (ROWS[i].we) begin
                wr(ROWS[i].adr, ROWS[i].dat);
            end else begin
                rdr(ROWS[i].adr);
                `CHK(rd, ROWS[i].exp)
            end
        end
    endtask

    initial begin
        {cyc_i, stb_i, we_i, cal_run, tgl_odd} = 5'h0;
        {adr_i, dat_i} = 40'h0;
        sel_i = 4'hf;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        run_rows();
        wr(OFS_BMR, {30'h0, MODE_PERIOD});
        wr(OFS_AMR, {30'h0, MODE_ONESHOT});
        wr(OFS_AILR, 32'h20);
        wr(OFS_IMR, 32'h1);
        wr(OFS_CTL, 32'h21);
        wait_for(3'b001);
        `CHK(trig_a, 1'b1)
        rdr(OFS_CTL);
        `CHK(rd, 32'h20)
        rdr(OFS_AR);
        `CHK(rd, 32'h20)
        rdr(OFS_RIS);
        `CHK(rd, 32'h1)
        `CHK(irq, 1'b1)
        wr(OFS_ICR, 32'h1);
        `CHK(irq, 1'b0)
        wr(OFS_AMR, {30'h0, MODE_PERIOD});
        wr(OFS_AILR, 32'h4000);
        wr(OFS_CTL, 32'h3);
        rdr(OFS_AR);
        q = rd;
        rdr(OFS_AR);
        `CHK(rd, q)
        wr(OFS_CTL, 32'h21);
        wr(OFS_AILR, 32'h30);
        rdr(OFS_AR);
        `CHK(rd > 32'h20 && rd <= 32'h30, 1'b1)
        wait_for(3'b001);
        wait_for(3'b001);
        `CHK(n, 49)
        wr(OFS_CTL, 32'h0);
        wr(OFS_CFG, {29'h0, CFG_SPLIT});
        wr(OFS_BMR, {30'h0, MODE_ONESHOT});
        wr(OFS_BPR, 32'h3);
        wr(OFS_BILR, 32'h4);
        wr(OFS_CTL, 32'h2100);
        wait_for(3'b010);
        `CHK(n >= 14 && n <= 18, 1'b1)
        rdr(OFS_BR);
        `CHK(rd, 32'h4)
        rdr(OFS_RIS);
        `CHK(rd, 32'h101)
        wr(OFS_ICR, 32'h101);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_BMR, {30'h0, MODE_CAPTURE});
            wr(OFS_BILR, 32'ha);
            wr(OFS_BMATCH, 32'h7);
            wr(OFS_CTL, {20'h0, evs[i], 10'h100});
            repeat (4) begin
                tgl_odd <= 1'b1;
                @(posedge clk_i);
                tgl_odd <= 1'b0;
                repeat (6) @(posedge clk_i);
            end
            rdr(OFS_BR);
            `CHK(rd, (evs[i] == EV_BOTH) ? 32'ha : 32'h8)
            rdr(OFS_RIS);
            `CHK(rd, (evs[i] == EV_BOTH) ? 32'h400 : 32'h0)
            wr(OFS_ICR, 32'h400);
            wr(OFS_CTL, 32'h0);
        end
        wr(OFS_CFG, {29'h0, CFG_RTC});
        rdr(OFS_AR);
        `CHK(rd, RTC_START)
        wr(OFS_AMATCH, 32'h2);
        wr(OFS_IMR, 32'h8);
        wr(OFS_CTL, 32'h13);
        cal_run <= 1'b1;
        wait_for(3'b100);
        rdr(OFS_AR);
        `CHK(rd, RTC_ROLL)
        rdr(OFS_RIS);
        `CHK(rd, 32'h8)
        wr(OFS_ICR, 32'h8);
        `CHK(irq, 1'b0)
        wr(OFS_CTL, 32'h3);
        rdr(OFS_AR);
        q = rd;
        repeat (60) @(posedge clk_i);
        rdr(OFS_AR);
        `CHK(rd, q)
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        run_rows();
        test_done();
    end
endmodule

`default_nettype wire
